// ### rtl/pcec_pkg.sv
// Package with register offsets, field positions, reset values and event codes
package pcec_pkg;
	// Register addresses in the management space
	localparam logic [4:0] PCEC_ADDR_CTRL2 = 5'h14;
	localparam logic [4:0] PCEC_ADDR_EVCNT = 5'h15;
	// Control register reset value and field positions
	localparam logic [15:0] PCEC_CTRL2_RESET = 16'h8006;
	localparam logic [15:0] PCEC_CTRL2_WMASK = 16'hc70f;
	localparam int PCEC_DS_HI = 15;
	localparam int PCEC_DS_LO = 14;
	localparam int PCEC_CLKFREQ_BIT = 10;
	localparam int PCEC_SDPOL_BIT = 9;
	localparam int PCEC_STICKY_BIT = 8;
	localparam int PCEC_ADC_BIT = 3;
	localparam int PCEC_PSCALE_BIT = 2;
	localparam int PCEC_NEGPD_BIT = 1;
	localparam int PCEC_LEGACY_BIT = 0;
	// Counter register fields
	localparam int PCEC_SEL_HI = 11;
	localparam int PCEC_SEL_LO = 8;
	localparam logic [3:0] PCEC_SEL_RESET = 4'h0;
	localparam logic [7:0] PCEC_COUNT_MAX = 8'hff;
	localparam logic [3:0] PCEC_SEL_LAST = 4'h6;
	// Downspeed policy codes and failed-attempt thresholds
	localparam logic [1:0] PCEC_DS_OFF = 2'h0;
	localparam logic [1:0] PCEC_DS_AFTER_TWO = 2'h1;
	localparam logic [1:0] PCEC_DS_AFTER_THREE = 2'h2;
	localparam logic [2:0] PCEC_FAIL_BASE = 3'h1;
	// Clock-out divider: 200 MHz core to 25 MHz or 100 MHz output
	localparam int PCEC_CLK_MHZ = 200;
	localparam int PCEC_LOW_MHZ = 25;
	localparam logic [2:0] PCEC_LOW_HALF = 3'(PCEC_CLK_MHZ / PCEC_LOW_MHZ / 2 - 1);

	// Management access request
	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] addr;
		logic [15:0] wdata;
	} pcec_req_t;

	// Event strobes from the data path
	typedef struct packed {
		logic collision;
		logic txFrame;
		logic txError;
		logic startDelimError;
		logic endDelimError;
		logic rxFrame;
		logic rxError;
	} pcec_events_t;

	// Control outputs toward the PHY core
	typedef struct packed {
		logic [1:0] downspeedPolicy;
		logic adcResolutionBoost;
		logic qualityPowerScaling;
		logic negotiationPowerDown;
		logic legacyEeeActivation;
	} pcec_ctrl_t;
endpackage : pcec_pkg

// ### rtl/pcec_top.sv
// Second control register and event counter behind the management port
`timescale 1ns/1ps
module pcec_top
	import pcec_pkg::*;
(
	// Clock and resets
	input wire logic clock,
	input wire logic rst,
	input wire logic softReset,
	// Management access
	input wire pcec_req_t req,
	output logic [15:0] rdata,
	output logic rvalid,
	// Strap and EEPROM status
	input wire logic strapSignalPolarity,
	input wire logic eepromDetected,
	// Pins and events
	input wire logic fibreSignalDetectInput,
	input wire pcec_events_t events,
	// Link-up attempt results
	input wire logic linkFailStrobe,
	input wire logic linkUpStrobe,
	// Outputs toward the core
	output pcec_ctrl_t ctrl,
	output logic downspeedRequest,
	output logic signalDetected,
	output logic clockOutputPin
);

	// Control and counter state
	logic [15:0] ctrl2_reg;
	logic [15:0] ctrl2_next;
	logic [3:0] sel_reg;
	logic [3:0] sel_next;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic strapPending_reg;
	logic strapPending_next;
	// Downspeed tracking
	logic [2:0] failCount_reg;
	logic [2:0] failCount_next;
	logic downspeed_reg;
	logic downspeed_next;
	// Synchronisers for the pin inputs
	logic [1:0] sdSync_reg;
	logic [1:0] strapSync_reg;
	logic [1:0] eeSync_reg;
	logic fibre_signal_detect_input_reg;
	logic fibre_signal_detect_input_next;
	// Clock-out divider
	logic [2:0] divCount_reg;
	logic [2:0] divCount_next;
	logic clock_output_pin_reg;
	logic clock_output_pin_next;
	logic eventHit;
	logic wrCtrl;
	logic wrCnt;
	logic rdCnt;

	// Two-flop synchronisers, kept out of reset so that the strap load
	// right after reset release sees settled pin levels
	always_ff @(posedge clock)
	begin
		sdSync_reg <= {sdSync_reg[0], fibreSignalDetectInput};
		strapSync_reg <= {strapSync_reg[0], strapSignalPolarity};
		eeSync_reg <= {eeSync_reg[0], eepromDetected};
	end

	// Access decode
	assign wrCtrl = req.valid && req.write && (req.addr == PCEC_ADDR_CTRL2);
	assign wrCnt = req.valid && req.write && (req.addr == PCEC_ADDR_EVCNT);
	assign rdCnt = req.valid && !req.write && (req.addr == PCEC_ADDR_EVCNT);

	// Selected event decode
	always_comb
	begin
		case (sel_reg)
			4'h0: eventHit = events.rxError;
			4'h1: eventHit = events.rxFrame;
			4'h2: eventHit = events.endDelimError;
			4'h3: eventHit = events.startDelimError;
			4'h4: eventHit = events.txError;
			4'h5: eventHit = events.txFrame;
			PCEC_SEL_LAST: eventHit = events.collision;
			default: eventHit = 1'b0;
		endcase
	end

	// Register file next state
	always_comb
	begin
		ctrl2_next = ctrl2_reg;
		sel_next = sel_reg;
		count_next = count_reg;
		strapPending_next = 1'b0;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		if (softReset && !ctrl2_reg[PCEC_STICKY_BIT])
		begin
			ctrl2_next = PCEC_CTRL2_RESET;
			sel_next = PCEC_SEL_RESET;
			strapPending_next = 1'b1;
		end
		if (strapPending_reg && !eeSync_reg[1])
		begin
			ctrl2_next[PCEC_SDPOL_BIT] = strapSync_reg[1];
		end
		if (wrCtrl)
		begin
			ctrl2_next = req.wdata & PCEC_CTRL2_WMASK;
		end
		if (eventHit && (count_reg != PCEC_COUNT_MAX))
		begin
			count_next = count_reg + 8'h01;
		end
		else if (eventHit)
		begin
			count_next = PCEC_COUNT_MAX;
		end
		if (wrCnt)
		begin
			sel_next = req.wdata[PCEC_SEL_HI:PCEC_SEL_LO];
		end
		// clear on read or selector change
		if (rdCnt || (sel_next != sel_reg))
		begin
			count_next = (eventHit && rdCnt && (sel_next == sel_reg)) ? 8'h01 : 8'h00;
		end
		if (req.valid && !req.write)
		begin
			rvalid_next = 1'b1;
			case (req.addr)
				PCEC_ADDR_CTRL2: rdata_next = ctrl2_reg;
				PCEC_ADDR_EVCNT: rdata_next = {4'h0, sel_reg, count_reg};
				default: rdata_next = 16'h0000;
			endcase
		end
	end

	// Downspeed failure count next state
	always_comb
	begin
		failCount_next = failCount_reg;
		downspeed_next = 1'b0;
		if (linkUpStrobe || (ctrl2_reg[PCEC_DS_HI:PCEC_DS_LO] == PCEC_DS_OFF))
		begin
			failCount_next = 3'h0;
		end
		else if (linkFailStrobe)
		begin
			// Policy code equals the failures seen before the final one
			if (failCount_reg == ({1'b0, ctrl2_reg[PCEC_DS_HI:PCEC_DS_LO]} + PCEC_FAIL_BASE
				- 3'h1))
			begin
				downspeed_next = 1'b1;
				failCount_next = 3'h0;
			end
			else
			begin
				failCount_next = failCount_reg + 3'h1;
			end
		end
	end

	// Downspeed registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			failCount_reg <= 3'h0;
			downspeed_reg <= 1'b0;
		end
		else
		begin
			failCount_reg <= failCount_next;
			downspeed_reg <= downspeed_next;
		end
	end

	// Signal detect next state
	always_comb
	begin
		fibre_signal_detect_input_next = ctrl2_reg[PCEC_SDPOL_BIT] ? sdSync_reg[1] : !sdSync_reg[1];
	end

	// Signal detect register
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			fibre_signal_detect_input_reg <= 1'b0;
		end
		else
		begin
			fibre_signal_detect_input_reg <= fibre_signal_detect_input_next;
		end
	end

	// Clock-out divider next state
	always_comb
	begin
		// divide for 25 MHz or toggle for high rate
		if (ctrl2_reg[PCEC_CLKFREQ_BIT])
		begin
			divCount_next = 3'h0;
			clock_output_pin_next = !clock_output_pin_reg;
		end
		else if (divCount_reg >= PCEC_LOW_HALF)
		begin
			divCount_next = 3'h0;
			clock_output_pin_next = !clock_output_pin_reg;
		end
		else
		begin
			divCount_next = divCount_reg + 3'h1;
			clock_output_pin_next = clock_output_pin_reg;
		end
	end

	// Clock-out registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			divCount_reg <= 3'h0;
			clock_output_pin_reg <= 1'b0;
		end
		else
		begin
			divCount_reg <= divCount_next;
			clock_output_pin_reg <= clock_output_pin_next;
		end
	end

	// Register file registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctrl2_reg <= PCEC_CTRL2_RESET;
			sel_reg <= PCEC_SEL_RESET;
			count_reg <= 8'h00;
			strapPending_reg <= 1'b1;
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			ctrl2_reg <= ctrl2_next;
			sel_reg <= sel_next;
			count_reg <= count_next;
			strapPending_reg <= strapPending_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Outputs from flip-flops
	assign rdata = rdata_reg;
	assign rvalid = rvalid_reg;
	assign ctrl.adcResolutionBoost = ctrl2_reg[PCEC_ADC_BIT];
	assign ctrl.qualityPowerScaling = ctrl2_reg[PCEC_PSCALE_BIT];
	assign ctrl.negotiationPowerDown = ctrl2_reg[PCEC_NEGPD_BIT];
	assign ctrl.legacyEeeActivation = ctrl2_reg[PCEC_LEGACY_BIT];
	assign ctrl.downspeedPolicy = ctrl2_reg[PCEC_DS_HI:PCEC_DS_LO];
	assign downspeedRequest = downspeed_reg;
	assign signalDetected = fibre_signal_detect_input_reg;
	assign clockOutputPin = clock_output_pin_reg;
endmodule : pcec_top

// ### sim/pcec_props.sv
// Checker for the control register and event counter ports
`timescale 1ns/1ps
module pcec_props
	import pcec_pkg::*;
(
	// Clock, reset, management port
	input wire logic clock,
	input wire logic rst,
	input wire pcec_req_t req,
	input wire logic [15:0] rdata,
	input wire logic rvalid,
	// Events and control
	input wire pcec_events_t events,
	input wire logic linkFailStrobe,
	input wire pcec_ctrl_t ctrl,
	input wire logic downspeedRequest
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Request decodes
	wire rdCtl = req.valid && !req.write && req.addr == PCEC_ADDR_CTRL2;
	wire rdCnt = req.valid && !req.write && req.addr == PCEC_ADDR_EVCNT;
	wire wrCtl = req.valid && req.write && req.addr == PCEC_ADDR_CTRL2;
	wire [5:0] wrBits = {req.wdata[15:14], req.wdata[3:0]};
	a_read_answer: assert property (rdCtl || rdCnt |=> rvalid)
		else $error("no answer");
	a_reserved_zero: assert property (rvalid |->
		(rdata & ($past(rdCtl) ? 16'h38f0 : 16'hf000)) == 16'h0000) else $error("reserved set");
	a_ctrl_mirror: assert property (rvalid && $past(rdCtl) |->
		{rdata[15:14], rdata[3:0]} == $past(ctrl)) else $error("ctrl differs");
	a_ctrl_write: assert property (wrCtl |=> ctrl == $past(wrBits))
		else $error("write lost");
	a_read_clears: assert property (rdCnt && events == 7'h00 ##1 rdCnt |=>
		rdata[7:0] == 8'h00) else $error("count kept");
	a_read_event: assert property (rdCnt && events == 7'h7f ##1 rdCnt &&
		rdata[11:8] <= PCEC_SEL_LAST |=> rdata[7:0] == 8'h01) else $error("event lost");
	a_undef_hold: assert property (rdCnt && events == 7'h7f ##1 rdCnt &&
		rdata[11:8] > PCEC_SEL_LAST |=> rdata[7:0] == 8'h00) else $error("code counted");
	a_ds_cause: assert property (downspeedRequest |-> $past(linkFailStrobe) &&
		$past(ctrl.downspeedPolicy) != PCEC_DS_OFF ##1 !downspeedRequest) else $error("stray");
	// Main scenarios reached
	cover property (wrCtl);
	cover property (rdCnt ##1 rdCnt);
	cover property (downspeedRequest);
endmodule : pcec_props
bind pcec_top pcec_props u_props (.clock, .rst, .req, .rdata, .rvalid, .events,
	.linkFailStrobe, .ctrl, .downspeedRequest);

// ### sim/pcec_mgr.sv
// Station manager model: management requests and event strobes
`timescale 1ns/1ps
module pcec_mgr
	import pcec_pkg::*;
(
	// Read answer in
	input wire logic clock,
	input wire logic [15:0] rdata,
	input wire logic rvalid,
	// Requests and events out
	output pcec_req_t req = '0,
	output pcec_events_t events = '0
);
	// One write; released fields invert so stale values are never trusted
	task automatic wr(input logic [4:0] a, input logic [15:0] d, input bit raw);
		req = '{1'b1, 1'b1, a,
			raw ? d : d & (a == PCEC_ADDR_CTRL2 ? PCEC_CTRL2_WMASK : 16'h0f00)};
		@(negedge clock);
		req = pcec_req_t'({1'b0, ~req[21:0]});
		@(negedge clock);
	endtask : wr
	// One or two back-to-back reads, events strobed in the first cycle
	task automatic rd(input logic [4:0] a, input pcec_events_t ev, input bit two,
		output logic [15:0] d0, output logic [15:0] d1);
		req = '{1'b1, 1'b0, a, ~req.wdata};
		events = ev;
		@(negedge clock);
		events = '0;
		d0 = rvalid ? rdata : 16'hxxxx;
		req.valid = two;
		@(negedge clock);
		d1 = rvalid ? rdata : 16'hxxxx;
		req = pcec_req_t'({1'b0, ~req[21:0]});
		@(negedge clock);
	endtask : rd
	// Hold event strobes for n cycles, then one quiet cycle
	task automatic pulse(input pcec_events_t ev, input int n);
		events = ev;
		repeat (n) @(negedge clock);
		events = '0;
		@(negedge clock);
	endtask : pulse
endmodule : pcec_mgr

// ### sim/tb_top.sv
// Self-checking bench for the control register and event counter
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
	$display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_top
	import pcec_pkg::*;
;
	logic clock = 1'b0, rst = 1'b1, softReset = 1'b0;
	logic linkFailStrobe = 1'b0, linkUpStrobe = 1'b0;
	logic strap = 1'b1, eeDet = 1'b0, sigPin = 1'b1;
	logic rvalid, downspeedRequest, signalDetected, clockOutputPin, lastClk;
	logic [15:0] rdata, d0, d1;
	pcec_req_t req;
	pcec_events_t events;
	pcec_ctrl_t ctrl;
	int error_cnt = 0, compares = 0, dsCnt = 0, rises = 0, p;
	// Raw control write beside read-back after soft reset
	logic [31:0] rows [4] = '{32'hffff_c70f, 32'h0000_8206, 32'h4509_4509, 32'h0100_0100};
	// Clock
	always #2.5 clock = ~clock;
	// Count downspeed pulses and clock-out rising edges
	always @(posedge clock)
	begin
		dsCnt += downspeedRequest;
		rises += clockOutputPin && !lastClk;
		lastClk = clockOutputPin;
	end
	// Device and station manager
	pcec_top dut (.clock, .rst, .softReset, .req, .rdata, .rvalid, .strapSignalPolarity(strap),
		.eepromDetected(eeDet), .fibreSignalDetectInput(sigPin), .events, .linkFailStrobe,
		.linkUpStrobe, .ctrl, .downspeedRequest, .signalDetected, .clockOutputPin);
	pcec_mgr mgr (.clock, .rdata, .rvalid, .req, .events);
	// Verdict and end of run
	task automatic stop_test();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// Main sequence
	initial
	begin
		repeat (2) @(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		foreach (rows[i])
		begin
			mgr.wr(PCEC_ADDR_CTRL2, rows[i][31:16], 1'b1);
			softReset = 1'b1;
			linkUpStrobe = 1'b1;
			@(negedge clock);
			softReset = 1'b0;
			linkUpStrobe = 1'b0;
			repeat (20) @(negedge clock);
			rises = 0;
			repeat (80) @(negedge clock);
			`CHK(rises, rows[i][10] ? 40 : 10)
			mgr.rd(PCEC_ADDR_CTRL2, '0, 1'b0, d0, d1);
			`CHK(d0, rows[i][15:0])
			`CHK(signalDetected, rows[i][9])
			`CHK(ctrl.downspeedPolicy, rows[i][15:14])
			`CHK(ctrl.adcResolutionBoost, rows[i][3])
			`CHK(ctrl.qualityPowerScaling, rows[i][2])
			`CHK(ctrl.negotiationPowerDown, rows[i][1])
			`CHK(ctrl.legacyEeeActivation, rows[i][0])
			p = rows[i][15:14];
			dsCnt = 0;
			for (int n = 0; n <= p; n++)
			begin
				linkFailStrobe = 1'b1;
				@(negedge clock);
				linkFailStrobe = 1'b0;
				@(negedge clock);
				`CHK(dsCnt, int'(p != 0 && n == p))
			end
		end
		// Selector codes 0 to 7, other events ignored, read with event
		for (int k = 0; k < 8; k++)
		begin
			mgr.wr(PCEC_ADDR_EVCNT, 16'(k << 8), 1'b0);
			mgr.pulse(~(7'h01 << k), 1);
			mgr.pulse(7'h01 << k, 2);
			mgr.rd(PCEC_ADDR_EVCNT, 7'h7f, 1'b1, d0, d1);
			`CHK(d0, ({4'h0, 4'(k), k < 7 ? 8'h02 : 8'h00}))
			`CHK(d1, ({8'(k), 8'(k < 7)}))
		end
		// Saturation, then clear on read
		mgr.wr(PCEC_ADDR_EVCNT, 16'h0000, 1'b0);
		mgr.pulse(7'h01, 260);
		mgr.rd(PCEC_ADDR_EVCNT, 7'h01, 1'b1, d0, d1);
		`CHK(d0, 16'h00ff)
		`CHK(d1, 16'h0001)
		mgr.rd(PCEC_ADDR_EVCNT, '0, 1'b1, d0, d1);
		`CHK(d1, 16'h0000)
		// Mid-run resets, EEPROM present then absent: only the latter takes the strap
		sigPin = 1'b0;
		for (int e = 1; e >= 0; e--)
		begin
			eeDet = e[0];
			mgr.wr(PCEC_ADDR_EVCNT, 16'h0300, 1'b0);
			mgr.pulse(7'h08, 3);
			rst = 1'b1;
			repeat (2) @(negedge clock);
			rst = 1'b0;
			`CHK(ctrl, pcec_ctrl_t'(6'h26))
			`CHK(({rvalid, downspeedRequest, clockOutputPin}), 3'h0)
			repeat (2) @(negedge clock);
			mgr.rd(PCEC_ADDR_EVCNT, '0, 1'b0, d0, d1);
			`CHK(d0, 16'h0000)
			mgr.rd(PCEC_ADDR_CTRL2, '0, 1'b0, d0, d1);
			`CHK(d0, e ? 16'h8006 : 16'h8206)
			`CHK(signalDetected, e[0])
		end
		stop_test();
	end
endmodule : tb_top
